// ### design/mcb_backup_ctrl.sv
// Sequencer for card backup, power-on restore and compare, with APB registers.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module mcb_backup_ctrl
  import mcb_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYCLES_DFLT,
  parameter int NUM_BANKS   = NUM_BANKS_DFLT,
  parameter int BANK_W      = 4
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [7:0]        paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              backup_sel_i,
  input  wire logic              push_sw_i,
  input  wire logic              autoxfer_sel_i,
  input  wire logic              wprot_i,
  input  wire logic [1:0]        mode_req_i,
  output logic      [1:0]        mode_o,
  output logic                   prog_lock_o,
  output logic                   auto_go_o,
  output logic                   file_req_o,
  output logic      [1:0]        file_op_o,
  output logic      [2:0]        file_sel_o,
  output logic      [BANK_W-1:0] file_bank_o,
  input  wire logic              file_done_i,
  input  wire logic              file_ok_i,
  input  wire logic              io_memory_hold_bit_i,
  input  wire logic              io_keep_set_i,
  input  wire logic              forced_state_hold_bit_i,
  input  wire logic              forced_keep_set_i,
  output logic                   clr_io_o,
  output logic                   clr_forced_o,
  output logic                   irq_o
);

  typedef struct packed {
    mcb_state_e       state;
    mcb_op_e          op;
    logic [2:0]       file;
    logic [BANK_W-1:0] bank;
    logic [HOLD_W-1:0] hold_cnt;
    logic             armed;
    logic             lock;
    logic [1:0]       mode;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq;
    logic [IRQ_W-1:0] mask;
    logic [31:0]      prdata;
    logic             slverr;
    logic             auto_go;
    logic             clr_io;
    logic             clr_forced;
  } mcb_regs_s;

  mcb_regs_s st;
  mcb_regs_s next_st;

  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
  localparam logic [BANK_W-1:0] BANK_LAST = BANK_W'(NUM_BANKS - 1);

  // Register index 0..3 for a mapped word, 4 for anything else.
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      OFS_CTRL: reg_index = 3'h0;
      OFS_STAT: reg_index = 3'h1;
      OFS_IRQ:  reg_index = 3'h2;
      OFS_MASK: reg_index = 3'h3;
      default:  reg_index = 3'h4;
    endcase
  endfunction

  logic             setup;
  logic             wr_acc;
  logic [IRQ_W-1:0] ev;
  logic             hold_hit;

  assign setup    = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign hold_hit = (st.state == ST_IDLE) && st.armed && push_sw_i
                    && (st.hold_cnt == HOLD_LAST);

  always_comb begin
    next_st            = st;
    ev                 = '0;
    next_st.auto_go    = 1'b0;
    next_st.clr_io     = 1'b0;
    next_st.clr_forced = 1'b0;
    next_st.slverr     = 1'b0;
    // No mode gating here: requests are honoured in any mode, while a lock pins program.
    next_st.mode       = st.lock ? MODE_PROG : mode_req_i; // [R3] [R11]

    case (st.state)
      ST_BOOT: begin
        next_st.state = ST_IDLE;
        if (backup_sel_i && !wprot_i) begin
          // Restore wins: the auto-transfer pulse is withheld.
          next_st.state = ST_WAIT; // [R4] [R6]
          next_st.op    = OP_RESTORE;
          next_st.file  = F_PROG; // [R5]
          next_st.bank  = '0;
        end else begin
          if (backup_sel_i) begin
            ev[IRQ_SKIPPED] = 1'b1; // [R7]
          end
          next_st.auto_go = autoxfer_sel_i;
        end
      end
      ST_IDLE: begin
        if (!push_sw_i) begin
          next_st.hold_cnt = '0; // [R15]
          next_st.armed    = 1'b1;
        end else if (hold_hit) begin
          next_st.state    = ST_WAIT;
          next_st.op       = backup_sel_i ? OP_BACKUP : OP_COMPARE; // [R1] [R12]
          next_st.file     = F_PROG; // [R2]
          next_st.bank     = '0;
          next_st.armed    = 1'b0;
          next_st.hold_cnt = '0;
        end else if (st.armed) begin
          next_st.hold_cnt = st.hold_cnt + 1'b1; // [R15]
        end
      end
      ST_WAIT: begin
        if (file_done_i) begin
          if (st.file == F_BANK && st.op == OP_RESTORE && !file_ok_i) begin
            // Missing bank file ends the bank walk, later banks stay.
            next_st.file = F_SYM; // [R14]
          end else begin
            if (!file_ok_i) begin
              if (st.op == OP_COMPARE) begin
                ev[IRQ_MISMATCH] = 1'b1;
              end else begin
                ev[IRQ_ERROR] = 1'b1;
              end
            end
            if (st.file == F_BANK && st.bank != BANK_LAST) begin
              next_st.bank = st.bank + 1'b1; // [R14]
            end else begin
              next_st.file = st.file + 3'h1; // [R2]
            end
          end
          if ((st.file == F_BANK && (next_st.file == F_SYM) && !st.ctrl[CTRL_EXTRAS])
              || st.file == F_INDEX) begin
            next_st.state = ST_FINISH; // [R13]
          end
        end
      end
      ST_FINISH: begin
        next_st.state = ST_IDLE;
        ev[IRQ_DONE]  = 1'b1;
        if (st.op == OP_BACKUP) begin
          next_st.lock = 1'b1; // [R11]
        end
        if (st.op == OP_RESTORE) begin
          next_st.clr_io     = !(io_memory_hold_bit_i && io_keep_set_i); // [R8] [R9]
          next_st.clr_forced = !(forced_state_hold_bit_i && forced_keep_set_i); // [R8] [R10]
        end
        next_st.op = OP_NONE;
      end
      default: next_st.state = ST_IDLE;
    endcase

    // Register reads are latched in setup so the access phase ends at once.
    if (setup) begin
      next_st.prdata = '0;
      case (reg_index(paddr_i))
        3'h0: next_st.prdata[CTRL_W-1:0] = st.ctrl;
        3'h1: next_st.prdata[8:0] = {st.lock, st.mode, st.op, st.file, st.state == ST_IDLE};
        3'h2: next_st.prdata[IRQ_W-1:0] = st.irq;
        3'h3: next_st.prdata[IRQ_W-1:0] = st.mask;
        default: next_st.prdata = '0;
      endcase
      // The decode error is latched with the read data, so the access phase needs no decode.
      next_st.slverr = (reg_index(paddr_i) == 3'h4);
    end
    next_st.irq = st.irq;
    if (wr_acc) begin
      case (reg_index(paddr_i))
        3'h0: next_st.ctrl = pwdata_i[CTRL_W-1:0];
        3'h2: next_st.irq  = st.irq & ~pwdata_i[IRQ_W-1:0];
        3'h3: next_st.mask = pwdata_i[IRQ_W-1:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end
    // An event in the clearing cycle survives the write-one-to-clear.
    next_st.irq = next_st.irq | ev;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st          <= '0;
      st.state    <= ST_BOOT;
      st.op       <= OP_NONE;
      st.mode     <= MODE_PROG;
      st.ctrl     <= CTRL_RST;
      st.irq      <= IRQ_RST;
      st.mask     <= IRQ_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_o     = st.prdata;
  assign pready_o     = 1'b1;
  assign pslverr_o    = psel_i && penable_i && st.slverr;
  assign mode_o       = st.mode;
  assign prog_lock_o  = st.lock;
  assign auto_go_o    = st.auto_go;
  assign file_req_o   = (st.state == ST_WAIT);
  assign file_op_o    = st.op;
  assign file_sel_o   = st.file;
  assign file_bank_o  = st.bank;
  assign clr_io_o     = st.clr_io;
  assign clr_forced_o = st.clr_forced;
  assign irq_o        = |(st.irq & st.mask);

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_BACKUP_START: assert property (hold_hit && backup_sel_i |=> // [R1]
    st.state == ST_WAIT && st.op == OP_BACKUP && st.file == F_PROG)
    else $error("Backup did not start after hold time.");
  AST_COMPARE_START: assert property (hold_hit && !backup_sel_i |=> // [R12]
    st.state == ST_WAIT && st.op == OP_COMPARE)
    else $error("Compare did not start after hold time.");
  AST_EARLY_RELEASE: assert property (st.state == ST_IDLE && !push_sw_i |=> // [R15]
    st.hold_cnt == '0 && st.state == ST_IDLE)
    else $error("Hold timer not restarted on release.");
  AST_RESTORE_BOOT: assert property (st.state == ST_BOOT && backup_sel_i && !wprot_i // [R4]
    |=> st.op == OP_RESTORE && file_req_o && !auto_go_o)
    else $error("Power-on restore not started.");
  AST_RESTORE_PRIO: assert property (st.state == ST_BOOT && backup_sel_i && !wprot_i // [R6]
    && autoxfer_sel_i |=> !auto_go_o [*2])
    else $error("Auto-transfer ran despite restore.");
  AST_WPROT_SKIP: assert property (st.state == ST_BOOT && backup_sel_i && wprot_i // [R7]
    |=> st.state == ST_IDLE && st.op == OP_NONE && st.irq[IRQ_SKIPPED])
    else $error("Restore not skipped under write protect.");
  AST_BANK_STOP: assert property (file_req_o && st.op == OP_RESTORE // [R14]
    && st.file == F_BANK && file_done_i && !file_ok_i |=> st.file != F_BANK)
    else $error("Bank walk continued past missing file.");
  AST_CLEAR_IO: assert property (st.state == ST_FINISH && st.op == OP_RESTORE // [R8]
    && !(io_memory_hold_bit_i && io_keep_set_i) |=> clr_io_o ##1 !clr_io_o)
    else $error("I/O memory not cleared after restore.");
  AST_KEEP_IO: assert property (st.state == ST_FINISH && io_memory_hold_bit_i // [R9]
    && io_keep_set_i |=> !clr_io_o)
    else $error("I/O memory cleared despite hold.");
  AST_KEEP_FORCED: assert property (st.state == ST_FINISH && st.op == OP_RESTORE // [R10]
    |=> clr_forced_o == !($past(forced_state_hold_bit_i) && $past(forced_keep_set_i)))
    else $error("Forced state clear wrong after restore.");
  AST_PROG_LOCK: assert property (st.state == ST_FINISH && st.op == OP_BACKUP // [R11]
    |=> prog_lock_o ##1 (mode_o == MODE_PROG && prog_lock_o) [*3])
    else $error("Program mode not held after backup.");
  AST_FILE_ORDER: assert property (file_req_o && file_done_i && st.file == F_PROG // [R2]
    |=> st.file == F_PARAM && file_req_o)
    else $error("Fixed file order broken.");
  AST_NO_EXTRAS: assert property (file_req_o && file_done_i && st.file == F_BANK // [R13]
    && st.bank == BANK_LAST && !st.ctrl[CTRL_EXTRAS] && file_ok_i |=> st.state == ST_FINISH)
    else $error("Extra files sent with option off.");

  // Hold timer and start interlocks.
  AST_NO_EARLY_START: assert property (st.state == ST_IDLE && !hold_hit // [R15]
    |=> !file_req_o)
    else $error("Transfer started before the hold time.");
  AST_HOLD_COUNT: assert property (st.state == ST_IDLE && st.armed && push_sw_i // [R15]
    && !hold_hit |=> st.hold_cnt == $past(st.hold_cnt) + 1'b1)
    else $error("Hold timer did not advance.");
  AST_NO_REARM: assert property (st.state == ST_IDLE && !st.armed && push_sw_i // [R15]
    |=> st.state == ST_IDLE && st.hold_cnt == '0)
    else $error("Held switch started a second operation.");
  AST_BUSY_IGNORE: assert property (st.state == ST_WAIT && st.hold_cnt == '0 // [R15]
    |=> st.hold_cnt == '0)
    else $error("Hold timer ran during a transfer.");

  // Mode handling and the program lock.
  AST_MODE_FREE: assert property (!prog_lock_o // [R3]
    |=> mode_o == $past(mode_req_i))
    else $error("Requested mode not granted while unlocked.");
  AST_LOCK_STICKY: assert property (prog_lock_o // [R11]
    |=> prog_lock_o)
    else $error("Program lock dropped before a power cycle.");
  AST_LOCK_MODE: assert property (prog_lock_o // [R11]
    |=> mode_o == MODE_PROG)
    else $error("Locked controller left program mode.");
  AST_COMPARE_NO_LOCK: assert property (st.state == ST_FINISH && st.op != OP_BACKUP // [R12]
    |=> prog_lock_o == $past(prog_lock_o))
    else $error("Lock changed by an operation other than backup.");

  // Start-up restore and auto-transfer.
  AST_BOOT_ONCE: assert property (st.state != ST_BOOT // [R4]
    |=> st.state != ST_BOOT)
    else $error("Start-up phase entered without a reset.");
  AST_RESTORE_FROM_BOOT: assert property (st.state != ST_BOOT && st.op != OP_RESTORE // [R4]
    |=> st.op != OP_RESTORE)
    else $error("Restore started outside start-up.");
  AST_WPROT_NO_REQ: assert property (st.state == ST_BOOT && wprot_i // [R7]
    |=> !file_req_o)
    else $error("Card read under write protect.");
  AST_AUTO_BOOT_ONLY: assert property (auto_go_o // [R6]
    |-> $past(st.state) == ST_BOOT)
    else $error("Auto-transfer pulse outside start-up.");
  AST_AUTO_PULSE: assert property (auto_go_o // [R6]
    |=> !auto_go_o)
    else $error("Auto-transfer pulse longer than one cycle.");

  // File sequence, bank walk and results.
  AST_RESTORE_WHOLE: assert property (file_req_o && file_done_i && st.file != F_BANK // [R5]
    && st.file != F_INDEX |=> file_req_o && st.op == $past(st.op))
    else $error("Operation split between files.");
  AST_BANK_ASCEND: assert property (file_req_o && file_done_i && st.file == F_BANK // [R14]
    && st.bank != BANK_LAST && (file_ok_i || st.op != OP_RESTORE)
    |=> st.file == F_BANK && st.bank == $past(st.bank) + 1'b1)
    else $error("Bank files not taken in ascending order.");
  AST_EXTRAS_ON: assert property (file_req_o && file_done_i && st.file == F_BANK // [R13]
    && st.bank == BANK_LAST && file_ok_i && st.ctrl[CTRL_EXTRAS]
    |=> st.file == F_SYM && file_req_o)
    else $error("Extra files skipped with option on.");
  AST_COMPARE_MISS: assert property (file_req_o && st.op == OP_COMPARE && file_done_i // [R12]
    && !file_ok_i |=> st.irq[IRQ_MISMATCH])
    else $error("Compare mismatch not flagged.");
  AST_BACKUP_ERROR: assert property (file_req_o && st.op == OP_BACKUP && file_done_i // [R2]
    && !file_ok_i |=> st.irq[IRQ_ERROR])
    else $error("Backup write failure not flagged.");

  // Clearing after a restore.
  AST_CLEAR_FORCED: assert property (st.state == ST_FINISH && st.op == OP_RESTORE // [R8]
    && !(forced_state_hold_bit_i && forced_keep_set_i) |=> clr_forced_o)
    else $error("Forced states not cleared after restore.");
  AST_CLR_ORIGIN: assert property (clr_io_o || clr_forced_o // [R8]
    |-> $past(st.state) == ST_FINISH && $past(st.op) == OP_RESTORE)
    else $error("Memory cleared outside a restore.");
  AST_CLR_PULSE: assert property (clr_io_o || clr_forced_o // [R8]
    |=> !clr_io_o && !clr_forced_o)
    else $error("Clear pulse longer than one cycle.");

  COV_BACKUP: cover property (st.state == ST_FINISH && st.op == OP_BACKUP);
  COV_COMPARE_MISS: cover property (st.op == OP_COMPARE && file_done_i && !file_ok_i);
  COV_RESTORE: cover property (st.state == ST_FINISH && st.op == OP_RESTORE);
  COV_BANK_STOP: cover property (st.file == F_BANK && st.op == OP_RESTORE && file_done_i
    && !file_ok_i);
  COV_WPROT_SKIP: cover property (st.state == ST_BOOT && backup_sel_i && wprot_i);

endmodule

// ### design/mcb_pkg.sv
// Package with constants and types for the memory card backup controller.
// Operation
// R1: Switch on plus 3 s hold starts backup.
// R2: Backup writes fixed files, no operator naming.
// R3: Backup accepted in any operating mode.
// R4: Switch on at power-up restores card files.
// R5: Restore loads all areas as one operation.
// R6: Power-on restore overrides start-up auto-transfer.
// R7: Write-protect switch on skips the restore.
// R8: After restore clear I/O and forced states.
// R9: Saved I/O hold bit plus setting keeps I/O.
// R10: Saved forced hold bit plus setting keeps forces.
// R11: After backup stay in program mode.
// R12: Switch off plus 3 s hold starts compare.
// R13: Option adds symbol, comment, index files.
// R14: Banks load ascending, stop at first missing.
// R15: Early release starts nothing, timer restarts.
package mcb_pkg;
  localparam int HOLD_TIME_MS      = 3000;
  localparam int CLK_KHZ           = 250000;
  localparam int HOLD_CYCLES_DFLT  = HOLD_TIME_MS * CLK_KHZ;
  localparam int NUM_BANKS_DFLT    = 13;
  localparam int HOLD_W            = 30;
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_IRQ   = 8'h08;
  localparam logic [7:0] OFS_MASK  = 8'h0c;
  localparam int CTRL_EXTRAS       = 0;
  localparam int CTRL_W            = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 1'h0;
  localparam int IRQ_DONE          = 0;
  localparam int IRQ_MISMATCH      = 1;
  localparam int IRQ_ERROR         = 2;
  localparam int IRQ_SKIPPED       = 3;
  localparam int IRQ_W             = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  localparam logic [1:0] MODE_PROG = 2'h0;
  localparam logic [2:0] F_PROG    = 3'h0;
  localparam logic [2:0] F_PARAM   = 3'h1;
  localparam logic [2:0] F_IO      = 3'h2;
  localparam logic [2:0] F_BANK    = 3'h3;
  localparam logic [2:0] F_SYM     = 3'h4;
  localparam logic [2:0] F_CMT     = 3'h5;
  localparam logic [2:0] F_INDEX   = 3'h6;
  typedef enum logic [1:0] {OP_NONE, OP_BACKUP, OP_RESTORE, OP_COMPARE} mcb_op_e;
  typedef enum {ST_BOOT, ST_IDLE, ST_WAIT, ST_FINISH} mcb_state_e;
endpackage

// ### verification/mcb_card_model.sv
// Behavioural model of the card file engine that answers the transfer sequencer.
`timescale 1ns/100ps
module mcb_card_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       file_req_i,
  input  wire logic [2:0] file_sel_i,
  input  wire logic [3:0] file_bank_i,
  input  wire logic [3:0] miss_bank_i,
  input  wire logic [2:0] bad_sel_i,
  input  wire logic [3:0] delay_i,
  output logic            file_done_o,
  output logic            file_ok_o
);
  logic [3:0] cnt;
  logic       ok_val;
  // Bank files from the first missing number on are absent on the card.
  assign ok_val = !((file_sel_i == 3'h3) && (file_bank_i >= miss_bank_i))
                  && (file_sel_i != bad_sel_i);
  // Between answers the ok line toggles, so a stale value is never mistaken for a result.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt         <= 4'h0;
      file_done_o <= 1'b0;
      file_ok_o   <= 1'b0;
    end else if (!file_req_i || file_done_o) begin
      cnt         <= 4'h0;
      file_done_o <= 1'b0;
      file_ok_o   <= ~file_ok_o;
    end else if (cnt == delay_i) begin
      file_done_o <= 1'b1;
      file_ok_o   <= ok_val;
    end else begin
      cnt         <= cnt + 4'h1;
      file_ok_o   <= ~file_ok_o;
    end
  end
endmodule

// ### verification/tb_mcb_backup_ctrl.sv
// Self-checking bench for the card backup sequencer with a file engine model.
`timescale 1ns/100ps
module tb_mcb_backup_ctrl;
  import mcb_pkg::*;
  localparam int HOLD = 8;
  localparam int NB   = 4;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        bsel = 1'b1, push = 1'b0, axfer = 1'b1, wprot = 1'b0, err;
  logic [1:0]  mode_req = 2'h2, mode, fop;
  logic        lock, auto_go, freq, fdone, fok, clr_io, clr_fs, irq;
  logic        io_hold = 1'b1, io_keep = 1'b1, fs_hold = 1'b1, fs_keep = 1'b0;
  logic [2:0]  fsel, bad_sel = 3'h7;
  logic [3:0]  fbank, miss = 4'h2, dly = 4'h3;
  logic [6:0]  seq[$];
  int          fail_count = 0, total_checks = 0, n_auto = 0, n_cio = 0, n_cfs = 0;

  mcb_backup_ctrl #(.HOLD_CYCLES(HOLD), .NUM_BANKS(NB), .BANK_W(4)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .backup_sel_i(bsel), .push_sw_i(push),
    .autoxfer_sel_i(axfer), .wprot_i(wprot), .mode_req_i(mode_req), .mode_o(mode),
    .prog_lock_o(lock), .auto_go_o(auto_go), .file_req_o(freq), .file_op_o(fop),
    .file_sel_o(fsel), .file_bank_o(fbank), .file_done_i(fdone), .file_ok_i(fok),
    .io_memory_hold_bit_i(io_hold), .io_keep_set_i(io_keep),
    .forced_state_hold_bit_i(fs_hold), .forced_keep_set_i(fs_keep), .clr_io_o(clr_io),
    .clr_forced_o(clr_fs), .irq_o(irq));
  mcb_card_model card (
    .clock_i(clock_i), .rst_i(rst_i), .file_req_i(freq), .file_sel_i(fsel),
    .file_bank_i(fbank), .miss_bank_i(miss), .bad_sel_i(bad_sel), .delay_i(dly),
    .file_done_o(fdone), .file_ok_o(fok));

  always #2 clock_i = ~clock_i;

  always @(posedge clock_i) begin
    if (fdone === 1'b1 && freq === 1'b1) seq.push_back({fsel, (fsel == 3'h3) ? fbank : 4'h0});
    if (auto_go === 1'b1) n_auto++;
    if (clr_io === 1'b1) n_cio++;
    if (clr_fs === 1'b1) n_cfs++;
  end

  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clock_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic press(input int n);
    seq.delete();
    push <= 1'b1;
    repeat (n) @(posedge clock_i);
    push <= 1'b0;
  endtask

  function automatic logic [6:0] exp_code(input int i, input int nb);
    if (i < 3) return {i[2:0], 4'h0};
    if (i < 3 + nb) return {3'h3, 4'(i - 3)};
    return {3'(i + 1 - nb), 4'h0};
  endfunction

  // Checks the operation code, then the exact file order once the request drops.
  task automatic run_op(input logic [1:0] op, input int nb, input int ex);
    int n;
    n = 0;
    while (freq !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    check(fop, op);
    while (freq === 1'b1) @(posedge clock_i);
    check(seq.size(), 3 + nb + ex);
    foreach (seq[i]) check(seq[i], exp_code(i, nb));
    repeat (3) @(posedge clock_i);
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    run_op(OP_RESTORE, 3, 0);
    check(n_auto, 0);
    check(n_cio, 0);
    check(n_cfs, 1);
    apb(1'b0, OFS_IRQ, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    apb(1'b1, OFS_IRQ, 32'h0000_0001);
    apb(1'b1, OFS_MASK, 32'h0000_0002);
    apb(1'b0, OFS_MASK, 32'h0000_0000);
    check(rd, 32'h0000_0002);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(err, 1'b1);
    bsel    <= 1'b0;
    bad_sel <= F_PARAM;
    miss    <= 4'hf;
    dly     <= 4'h1;
    press(HOLD - 1);
    repeat (4) @(posedge clock_i);
    check(freq, 1'b0);
    press(HOLD);
    run_op(OP_COMPARE, NB, 0);
    check(irq, 1'b1);
    apb(1'b1, OFS_IRQ, 32'h0000_0003);
    @(posedge clock_i);
    check(irq, 1'b0);
    check(mode, 2'h2);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    bsel    <= 1'b1;
    bad_sel <= 3'h7;
    press(HOLD);
    run_op(OP_BACKUP, NB, 3);
    check({lock, mode}, {1'b1, 2'h0});
    // A power cycle with write protect on must skip the restore but free the mode.
    wprot <= 1'b1;
    rst_i <= 1'b1;
    seq.delete();
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    check(seq.size(), 0);
    check({lock, mode}, {1'b0, 2'h2});
    apb(1'b0, OFS_IRQ, 32'h0000_0000);
    check(rd, 32'h0000_0008);
    check(n_auto, 1);
    // A second power cycle restores again with the I/O hold dropped and the forced hold kept.
    wprot   <= 1'b0;
    io_hold <= 1'b0;
    fs_keep <= 1'b1;
    rst_i   <= 1'b1;
    seq.delete();
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    run_op(OP_RESTORE, NB, 0);
    check(n_auto, 1);
    check(n_cio, 1);
    check(n_cfs, 1);
    check(lock, 1'b0);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    print_verdict();
  end
endmodule
